//--- bcp_consts.svh
/*
  Constants for the cell protection block: register offsets, field
  positions, reset values, factory delay choices and timing counts.
  Assumes a 100 MHz system clock and a 10 kHz internal delay tick.
*/
`ifndef BCP_CONSTS_SVH
`define BCP_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BCP_OFS_CTRL 4'h0
`define BCP_OFS_STATUS 4'h4
`define BCP_OFS_COMPARE 4'h8
`define BCP_CTRL_PROTECT_BIT 0
`define BCP_CTRL_RESET 32'h00000001
`define BCP_RESP_OKAY 2'h0
`define BCP_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Clock and delay tick
// ----------------------------------------------------------------
`define BCP_CLK_KHZ 100000
`define BCP_OSC_KHZ 10
`define BCP_OSC_DIV (`BCP_CLK_KHZ / `BCP_OSC_KHZ)

// ----------------------------------------------------------------
// Factory delay selections, fixed at build time
// ----------------------------------------------------------------
`define BCP_OVC_SEL 2
`define BCP_UDC_SEL 3
`define BCP_DOC_SEL 2
`define BCP_COC_SEL 2
`define BCP_OVC_MS ((`BCP_OVC_SEL == 0) ? 250 : (`BCP_OVC_SEL == 1) ? 1000 : (`BCP_OVC_SEL == 2) ? 1250 : 4500)
`define BCP_UDC_MS ((`BCP_UDC_SEL == 0) ? 20 : (`BCP_UDC_SEL == 1) ? 96 : (`BCP_UDC_SEL == 2) ? 125 : 144)
`define BCP_DOC_MS ((`BCP_DOC_SEL == 0) ? 8 : (`BCP_DOC_SEL == 1) ? 16 : (`BCP_DOC_SEL == 2) ? 20 : 48)
`define BCP_COC_MS ((`BCP_COC_SEL == 0) ? 4 : (`BCP_COC_SEL == 1) ? 6 : (`BCP_COC_SEL == 2) ? 8 : 16)
`define BCP_SHORT_US 250
`define BCP_REC_MS 1

// ----------------------------------------------------------------
// Delay counts in ticks; the short delay rounds up
// ----------------------------------------------------------------
`define BCP_OVC_TICKS (`BCP_OVC_MS * `BCP_OSC_KHZ)
`define BCP_UDC_TICKS (`BCP_UDC_MS * `BCP_OSC_KHZ)
`define BCP_DOC_TICKS (`BCP_DOC_MS * `BCP_OSC_KHZ)
`define BCP_COC_TICKS (`BCP_COC_MS * `BCP_OSC_KHZ)
`define BCP_SHORT_TICKS ((`BCP_SHORT_US * `BCP_OSC_KHZ + 999) / 1000)
`define BCP_REC_TICKS (`BCP_REC_MS * `BCP_OSC_KHZ)

`endif

//--- bcp_pkg.sv
/*
  Types for the cell protection block.
  Assumes nothing beyond the constants header.
*/
package bcp_pkg;
  typedef enum logic [1:0] {CHG_NORMAL, CHG_OVERCHARGE} bcp_chg_t;
  typedef enum logic [1:0] {DSG_NORMAL, DSG_OVERDIS, DSG_PWRDN,
                            DSG_OVERCUR} bcp_dsg_t;
endpackage

//--- bcp_protect.sv
/*
  Cell protection state machine with an AXI4-Lite register slave.
  Assumes comparator results arrive synchronous to aclk and that the
  external switches follow the two gate outputs.
*/
`timescale 1ns/1ns
`include "bcp_consts.svh"

module bcp_timer
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic [15:0] limit,
  // Result
  output logic [15:0] cnt,
  output logic done
);
  // A lapse clears the count so a brief fault never accumulates.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run)
      cnt <= 16'h0000;
    else if (tick && cnt != limit)
      cnt <= cnt + 16'h0001;
  end
  assign done = run && (cnt == limit);
endmodule

module bcp_protect
  import bcp_pkg::*;
#(
  parameter int OSC_DIV = `BCP_OSC_DIV
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Comparator results
  input wire logic cell_over_charge,
  input wire logic cell_below_charge_release,
  input wire logic cell_under_discharge,
  input wire logic cell_above_discharge_release,
  input wire logic vm_ge_dis_oc,
  input wire logic vm_ge_short,
  input wire logic vm_above_chg_oc_min,
  input wire logic vm_below_neg_0v7,
  input wire logic vm_le_cell_minus_1v,
  input wire logic vm_cell_delta_le_1v3,
  input wire logic charger_present,
  input wire logic charger_above_1v7,
  // Switch and bias control
  output logic charge_gate_out,
  output logic discharge_gate_out,
  output logic pullup_en,
  output logic current_sink_en,
  output logic power_down
);

  // ----------------------------------------------------------------
  // Internal delay tick
  // ----------------------------------------------------------------
  logic [13:0] div_cnt;
  logic tick;
  wire div_wrap = (div_cnt == 14'(OSC_DIV - 1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= 14'h0000;
      tick <= 1'b0;
    end
    else
    begin
      div_cnt <= div_wrap ? 14'h0000 : div_cnt + 14'h0001;
      tick <= div_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Fault state and timers
  // ----------------------------------------------------------------
  bcp_chg_t chg_state;
  bcp_chg_t next_chg_state;
  bcp_dsg_t dsg_state;
  bcp_dsg_t next_dsg_state;
  logic [31:0] ctrl;
  wire protect_on = ctrl[`BCP_CTRL_PROTECT_BIT];
  wire overcharge_fault = (chg_state == CHG_OVERCHARGE);
  wire overdischarge_fault = (dsg_state == DSG_OVERDIS) ||
                             (dsg_state == DSG_PWRDN);
  wire discharge_overcurrent_fault = (dsg_state == DSG_OVERCUR);
  wire dsg_normal = (dsg_state == DSG_NORMAL);
  // Delays are fixed constants and no register reaches them.
  wire [15:0] overcharge_delay = 16'(`BCP_OVC_TICKS);
  wire [15:0] overdischarge_delay = 16'(`BCP_UDC_TICKS);
  wire [15:0] discharge_overcurrent_delay = 16'(`BCP_DOC_TICKS);
  wire [15:0] charge_overcurrent_delay = 16'(`BCP_COC_TICKS);
  wire [15:0] short_circuit_delay = 16'(`BCP_SHORT_TICKS);
  wire [15:0] recovery_delay = 16'(`BCP_REC_TICKS);

  wire oc_inhibit = overcharge_fault && cell_over_charge;
  wire ovc_run = !overcharge_fault && cell_over_charge;
  wire udc_run = dsg_normal && cell_under_discharge;
  wire doc_run = dsg_normal && vm_ge_dis_oc && !oc_inhibit;
  wire sc_run = dsg_normal && vm_ge_short && !oc_inhibit;
  // Overcharge release; a present charger holds the status.
  wire ovc_release = !charger_present &&
                     (vm_ge_dis_oc ? !cell_over_charge :
                      vm_above_chg_oc_min && cell_below_charge_release);
  wire udc_release = charger_present &&
                     (vm_below_neg_0v7 ? !cell_under_discharge :
                      cell_above_discharge_release);
  wire chg_rec_run = overcharge_fault && ovc_release;
  wire dsg_rec_run = (dsg_state == DSG_OVERDIS && udc_release) ||
                     (discharge_overcurrent_fault && vm_le_cell_minus_1v);
  logic ovc_done, udc_done, doc_done, sc_done, chg_rec_done, dsg_rec_done;
  logic [15:0] ovc_cnt, udc_cnt, doc_cnt, sc_cnt, chg_rec_cnt, dsg_rec_cnt;

  bcp_timer u_ovc (.aclk(aclk), .aresetn(aresetn), .run(ovc_run),
    .tick(tick), .limit(overcharge_delay), .cnt(ovc_cnt), .done(ovc_done));
  bcp_timer u_udc (.aclk(aclk), .aresetn(aresetn), .run(udc_run),
    .tick(tick), .limit(overdischarge_delay), .cnt(udc_cnt),
    .done(udc_done));
  bcp_timer u_doc (.aclk(aclk), .aresetn(aresetn), .run(doc_run),
    .tick(tick), .limit(discharge_overcurrent_delay), .cnt(doc_cnt),
    .done(doc_done));
  bcp_timer u_sc (.aclk(aclk), .aresetn(aresetn), .run(sc_run),
    .tick(tick), .limit(short_circuit_delay), .cnt(sc_cnt),
    .done(sc_done));
  bcp_timer u_chg_rec (.aclk(aclk), .aresetn(aresetn), .run(chg_rec_run),
    .tick(tick), .limit(recovery_delay), .cnt(chg_rec_cnt),
    .done(chg_rec_done));
  bcp_timer u_dsg_rec (.aclk(aclk), .aresetn(aresetn), .run(dsg_rec_run),
    .tick(tick), .limit(recovery_delay), .cnt(dsg_rec_cnt),
    .done(dsg_rec_done));

  always_comb
  begin
    next_chg_state = chg_state;
    case (chg_state)
      CHG_NORMAL: if (ovc_done) next_chg_state = CHG_OVERCHARGE;
      CHG_OVERCHARGE: if (chg_rec_done) next_chg_state = CHG_NORMAL;
      default: next_chg_state = CHG_NORMAL;
    endcase
  end

  always_comb
  begin
    next_dsg_state = dsg_state;
    case (dsg_state)
      DSG_NORMAL:
        if (udc_done)
          next_dsg_state = DSG_OVERDIS;
        else if (doc_done || sc_done)
          next_dsg_state = DSG_OVERCUR;
      DSG_OVERDIS:
        if (dsg_rec_done)
          next_dsg_state = DSG_NORMAL;
        else if (vm_cell_delta_le_1v3)
          next_dsg_state = DSG_PWRDN;
      DSG_PWRDN:
        if (charger_present && !vm_cell_delta_le_1v3)
          next_dsg_state = DSG_OVERDIS;
      DSG_OVERCUR: if (dsg_rec_done) next_dsg_state = DSG_NORMAL;
      default: next_dsg_state = DSG_NORMAL;
    endcase
  end

  // Outputs follow the next state so they switch with the state.
  wire next_od = (next_dsg_state == DSG_OVERDIS) ||
                 (next_dsg_state == DSG_PWRDN);
  // A depleted cell takes charge only from a charger above 1.7 V.
  wire zero_volt_ok = !cell_under_discharge || charger_above_1v7;
  wire next_chg_gate = protect_on && zero_volt_ok &&
                       (next_chg_state == CHG_NORMAL);
  wire next_dsg_gate = protect_on && (next_dsg_state == DSG_NORMAL);
  wire next_sink = (next_dsg_state == DSG_OVERCUR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chg_state <= CHG_NORMAL;
      dsg_state <= DSG_NORMAL;
      charge_gate_out <= 1'b0;
      discharge_gate_out <= 1'b0;
      pullup_en <= 1'b0;
      current_sink_en <= 1'b0;
      power_down <= 1'b0;
    end
    else
    begin
      chg_state <= next_chg_state;
      dsg_state <= next_dsg_state;
      charge_gate_out <= next_chg_gate;
      discharge_gate_out <= next_dsg_gate;
      pullup_en <= next_od;
      current_sink_en <= next_sink;
      power_down <= (next_dsg_state == DSG_PWRDN);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // One write and one read in flight; address and data in either order.
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire do_write = !awready && !wready && !bvalid;
  wire wr_ctrl = (wr_addr == `BCP_OFS_CTRL);
  wire wr_hit = wr_ctrl || (wr_addr == `BCP_OFS_STATUS) ||
                (wr_addr == `BCP_OFS_COMPARE);
  wire [31:0] status_word = {24'h000000, power_down, current_sink_en,
    pullup_en, discharge_gate_out, charge_gate_out,
    discharge_overcurrent_fault, overdischarge_fault, overcharge_fault};
  wire [31:0] compare_word = {20'h00000, charger_above_1v7,
    charger_present, vm_cell_delta_le_1v3, vm_le_cell_minus_1v,
    vm_below_neg_0v7, vm_above_chg_oc_min, vm_ge_short, vm_ge_dis_oc,
    cell_above_discharge_release, cell_under_discharge,
    cell_below_charge_release, cell_over_charge};
  wire rd_ctrl = (araddr == `BCP_OFS_CTRL);
  wire rd_stat = (araddr == `BCP_OFS_STATUS);
  wire rd_cmp = (araddr == `BCP_OFS_COMPARE);
  wire [31:0] rd_word = rd_ctrl ? ctrl : rd_stat ? status_word :
                        rd_cmp ? compare_word : 32'h00000000;
  wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                           {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `BCP_RESP_OKAY;
      wr_addr <= 4'h0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      ctrl <= `BCP_CTRL_RESET;
    end
    else
    begin
      if (aw_take)
      begin
        awready <= 1'b0;
        wr_addr <= {awaddr[3:2], 2'b00};
      end
      if (w_take)
      begin
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `BCP_RESP_OKAY : `BCP_RESP_SLVERR;
        if (wr_ctrl)
          ctrl <= {31'h00000000,
                   ((wr_data & strb_mask) | (ctrl & ~strb_mask)) >> 0 ==
                   32'h0 ? 1'b0 : ((wr_data[0] & wr_strb[0]) |
                   (ctrl[0] & ~wr_strb[0]))};
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `BCP_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (rd_ctrl || rd_stat || rd_cmp) ? `BCP_RESP_OKAY :
               `BCP_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_gates_normal;
    @(posedge aclk) disable iff (!aresetn)
    // The gate register lags reset release and an enable write by one edge.
    (dsg_normal && $past(dsg_normal && protect_on && aresetn)) |->
      discharge_gate_out;
  endproperty
  a_gates_normal: assert property (p_gates_normal)
    else $error("discharge gate off in normal mode");

  property p_off_cause;
    @(posedge aclk) disable iff (!aresetn)
    ($fell(discharge_gate_out) && $past(protect_on)) |->
      $past(udc_done || doc_done || sc_done);
  endproperty
  a_off_cause: assert property (p_off_cause)
    else $error("discharge gate off without expired timer");

  property p_recover;
    @(posedge aclk) disable iff (!aresetn)
    $rose(dsg_normal) |-> $past(dsg_rec_done);
  endproperty
  a_recover: assert property (p_recover)
    else $error("discharge side recovered without recovery timer");

  property p_ovc_count;
    @(posedge aclk) disable iff (!aresetn)
    $rose(overcharge_fault) |-> $past(ovc_cnt) == 16'(`BCP_OVC_TICKS);
  endproperty
  a_ovc_count: assert property (p_ovc_count)
    else $error("overcharge entered at wrong count");

  property p_short_count;
    @(posedge aclk) disable iff (!aresetn)
    sc_done |-> sc_cnt == 16'h0003;
  endproperty
  a_short_count: assert property (p_short_count)
    else $error("short delay not three ticks");

  property p_inhibit;
    @(posedge aclk) disable iff (!aresetn)
    (overcharge_fault && cell_over_charge) |-> (!doc_run && !sc_run);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("overcurrent detection active during overcharge");

  property p_pwrdn;
    @(posedge aclk) disable iff (!aresetn)
    (dsg_state == DSG_OVERDIS && vm_cell_delta_le_1v3 && !dsg_rec_done)
      |=> (dsg_state == DSG_PWRDN) && power_down;
  endproperty
  a_pwrdn: assert property (p_pwrdn)
    else $error("power-down not entered");

  property p_sink_off;
    @(posedge aclk) disable iff (!aresetn)
    overdischarge_fault |-> !current_sink_en && pullup_en;
  endproperty
  a_sink_off: assert property (p_sink_off)
    else $error("sink on in over-discharge");

  property p_overcur_bias;
    @(posedge aclk) disable iff (!aresetn)
    discharge_overcurrent_fault |-> current_sink_en && !pullup_en;
  endproperty
  a_overcur_bias: assert property (p_overcur_bias)
    else $error("bias wrong in overcurrent");

  property p_restart;
    @(posedge aclk) disable iff (!aresetn)
    !udc_run |=> udc_cnt == 16'h0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("timer did not restart");

  property p_tick;
    @(posedge aclk) disable iff (!aresetn)
    tick |=> !tick [*3];
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick faster than divider");

  c_overcharge: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(overcharge_fault));
  c_pwrdn: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(power_down));
  c_short: cover property (@(posedge aclk) disable iff (!aresetn)
    sc_done ##1 discharge_overcurrent_fault);
endmodule

//--- bcp_pack_model.sv
/*
  Pack model: cell, charger and load as seen through the comparators.
  Assumes the bench drives cell and pack-minus levels in millivolts.
*/
`timescale 1ns/1ns
module bcp_pack_model
#(
  parameter int OVC = 4300,
  parameter int OVR = 4200,
  parameter int UDC = 2800,
  parameter int UDR = 3000,
  parameter int DOC = 100,
  parameter int SHT = 500,
  parameter int CMIN = -100
)
(
  // Levels set by the bench
  input wire logic signed [15:0] cell_mv,
  input wire logic signed [15:0] vm_mv,
  input wire logic charger,
  // Bias from the device
  input wire logic pullup_en,
  // Comparator results
  output logic cell_over_charge,
  output logic cell_below_charge_release,
  output logic cell_under_discharge,
  output logic cell_above_discharge_release,
  output logic vm_ge_dis_oc,
  output logic vm_ge_short,
  output logic vm_above_chg_oc_min,
  output logic vm_below_neg_0v7,
  output logic vm_le_cell_minus_1v,
  output logic vm_cell_delta_le_1v3,
  output logic charger_present,
  output logic charger_above_1v7
);
  // ---------------------------------------------
  // Comparators
  // ---------------------------------------------
  // With no charger the pull-up drags pack-minus up to the cell.
  int vm;
  assign vm = (pullup_en && !charger) ? int'(cell_mv) : int'(vm_mv);
  assign cell_over_charge = cell_mv > OVC;
  assign cell_below_charge_release = cell_mv < OVR;
  assign cell_under_discharge = cell_mv < UDC;
  assign cell_above_discharge_release = cell_mv > UDR;
  assign vm_ge_dis_oc = vm >= DOC;
  assign vm_ge_short = vm >= SHT;
  assign vm_above_chg_oc_min = vm > CMIN;
  assign vm_below_neg_0v7 = vm < -700;
  assign vm_le_cell_minus_1v = vm <= int'(cell_mv) - 1000;
  assign vm_cell_delta_le_1v3 = int'(cell_mv) - vm <= 1300;
  assign charger_present = charger;
  assign charger_above_1v7 = charger;
endmodule

//--- testbench.sv
/*
  Self-checking bench for the cell protection block.
  Assumes the pack model supplies every comparator input.
*/
`timescale 1ns/1ns
`include "bcp_consts.svh"
module testbench;
  // A short tick keeps the long overcharge delay inside the run.
  localparam int D = 4;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, charger;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic cell_over_charge, cell_below_charge_release, cell_under_discharge;
  logic cell_above_discharge_release, vm_ge_dis_oc, vm_ge_short;
  logic vm_above_chg_oc_min, vm_below_neg_0v7, vm_le_cell_minus_1v;
  logic vm_cell_delta_le_1v3, charger_present, charger_above_1v7;
  logic charge_gate_out, discharge_gate_out, pullup_en;
  logic current_sink_en, power_down;
  logic signed [15:0] cell_mv, vm_mv;
  int failures, check_count;

  bcp_protect #(.OSC_DIV(D)) uut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .cell_over_charge, .cell_below_charge_release, .cell_under_discharge,
    .cell_above_discharge_release, .vm_ge_dis_oc, .vm_ge_short,
    .vm_above_chg_oc_min, .vm_below_neg_0v7, .vm_le_cell_minus_1v,
    .vm_cell_delta_le_1v3, .charger_present, .charger_above_1v7,
    .charge_gate_out, .discharge_gate_out, .pullup_en, .current_sink_en,
    .power_down);
  bcp_pack_model model (.cell_mv, .vm_mv, .charger, .pullup_en,
    .cell_over_charge, .cell_below_charge_release, .cell_under_discharge,
    .cell_above_discharge_release, .vm_ge_dis_oc, .vm_ge_short,
    .vm_above_chg_oc_min, .vm_below_neg_0v7, .vm_le_cell_minus_1v,
    .vm_cell_delta_le_1v3, .charger_present, .charger_above_1v7);

  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic sel_out(input int k);
    case (k)
      0: return charge_gate_out;
      1: return discharge_gate_out;
      2: return pullup_en;
      3: return current_sink_en;
      default: return power_down;
    endcase
  endfunction

  // Counts edges until the output takes the value; both bounds checked.
  task automatic wait_out(input string nm, input int k, input logic v,
                          input int lo, hi);
    int n;
    n = 0;
    while (sel_out(k) !== v && n <= hi)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    check({nm, " late"}, 32'(n <= hi), 32'h1);
    check({nm, " early"}, 32'(n >= lo), 32'h1);
  endtask

  task automatic drive(input int c, v, input logic ch);
    @(posedge aclk);
    cell_mv <= 16'(c);
    vm_mv <= 16'(v);
    charger <= ch;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    check("write resp", {30'h0, bresp}, {30'h0, er});
    check("write wait", 32'(n < 50), 32'h1);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 50)
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    check("read data", rdata, ed);
    check("read resp", {30'h0, rresp}, {30'h0, er});
    check("read wait", 32'(n < 50), 32'h1);
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_regs;
    axi_rd(`BCP_OFS_CTRL, 32'h00000001, `BCP_RESP_OKAY);
    axi_rd(`BCP_OFS_STATUS, 32'h00000018, `BCP_RESP_OKAY);
    axi_rd(`BCP_OFS_COMPARE, 32'h0000014A, `BCP_RESP_OKAY);
    axi_rd(4'hC, 32'h00000000, `BCP_RESP_SLVERR);
    axi_wr(`BCP_OFS_STATUS, 32'h00000000, `BCP_RESP_OKAY);
    axi_rd(`BCP_OFS_STATUS, 32'h00000018, `BCP_RESP_OKAY);
    axi_wr(4'hC, 32'h00000000, `BCP_RESP_SLVERR);
    axi_wr(`BCP_OFS_CTRL, 32'h00000000, `BCP_RESP_OKAY);
    wait_out("ctrl off", 0, 1'b0, 0, 4);
    axi_wr(`BCP_OFS_CTRL, 32'h00000001, `BCP_RESP_OKAY);
    wait_out("ctrl on", 1, 1'b1, 0, 4);
  endtask

  task automatic t_short;
    drive(3700, 600, 1'b0);
    wait_out("short", 1, 1'b0, 2 * D, 4 * D + 4);
    check("sink on", 32'(current_sink_en), 32'h1);
    check("pullup off", 32'(pullup_en), 32'h0);
    drive(3700, 0, 1'b0);
    wait_out("oc back", 1, 1'b1, 9 * D, 11 * D + 4);
    check("sink off", 32'(current_sink_en), 32'h0);
  endtask

  task automatic t_overcur;
    drive(3700, 200, 1'b0);
    repeat (100 * D) @(posedge aclk);
    drive(3700, 0, 1'b0);
    repeat (2 * D) @(posedge aclk);
    drive(3700, 200, 1'b0);
    wait_out("oc", 1, 1'b0, 199 * D, 201 * D + 4);
    drive(3700, 0, 1'b0);
    wait_out("oc rec", 1, 1'b1, 9 * D, 11 * D + 4);
  endtask

  task automatic t_overdis;
    drive(2500, 0, 1'b0);
    wait_out("ud", 1, 1'b0, 1439 * D, 1441 * D + 4);
    wait_out("pd", 4, 1'b1, 0, 20);
    check("ud pullup", 32'(pullup_en), 32'h1);
    check("ud sink", 32'(current_sink_en), 32'h0);
    check("zero volt", 32'(charge_gate_out), 32'h0);
    drive(2500, -1000, 1'b1);
    wait_out("pd exit", 4, 1'b0, 0, 20);
    wait_out("zv chg", 0, 1'b1, 0, 11 * D + 4);
    check("ud held", 32'(discharge_gate_out), 32'h0);
    drive(2900, -1000, 1'b1);
    wait_out("ud rec", 1, 1'b1, 9 * D, 11 * D + 4);
    check("rec pullup", 32'(pullup_en), 32'h0);
    drive(3700, 0, 1'b0);
  endtask

  task automatic t_overchg;
    drive(4400, 0, 1'b0);
    wait_out("ov", 0, 1'b0, 12499 * D, 12501 * D + 4);
    check("ov dsg", 32'(discharge_gate_out), 32'h1);
    drive(4400, 600, 1'b0);
    repeat (6 * D) @(posedge aclk);
    #1;
    check("ov no short", 32'(discharge_gate_out), 32'h1);
    drive(4250, 200, 1'b0);
    wait_out("ov rec", 0, 1'b1, 9 * D, 11 * D + 4);
    drive(3700, 0, 1'b0);
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // The whole run needs about 60000 edges; this bounds a hang.
  initial
  begin
    #900000;
    failures++;
    tally_and_finish();
  end

  initial
  begin
    failures = 0;
    check_count = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, charger} = 6'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'hF;
    wdata = 32'h00000000;
    cell_mv = 16'sd3700;
    vm_mv = 16'sd0;
    repeat (2) @(posedge aclk);
    #1;
    check("reset gate", 32'(charge_gate_out), 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    wait_out("start chg", 0, 1'b1, 0, 4);
    wait_out("start dsg", 1, 1'b1, 0, 4);
    t_regs();
    t_short();
    t_overcur();
    t_overdis();
    t_overchg();
    tally_and_finish();
  end
endmodule
